/* File: src/rpd_params.svh */
// constants of the request phase decode and parity block
`ifndef RPD_PARAMS_SVH
`define RPD_PARAMS_SVH

// apb register byte offsets
`define RPD_OFF_CTRL      8'h00
`define RPD_OFF_STATUS    8'h04
`define RPD_OFF_LAST_TXN  8'h08
`define RPD_OFF_IRQ_STAT  8'h0c
`define RPD_OFF_IRQ_EN    8'h10
`define RPD_OFF_IRQ_CLR   8'h14
`define RPD_OFF_PERR_CNT  8'h18

// ctrl fields
`define RPD_CTRL_CHECK_EN    0
`define RPD_CTRL_RST         32'h0000_0001

// status fields
`define RPD_ST_ADDRESS_ERROR_LINE_CFG      0
`define RPD_ST_BUS_RESET     1
`define RPD_ST_BUSY          2

// last transaction fields
`define RPD_LT_TXN_LSB       0
`define RPD_LT_ASZ_LSB       4
`define RPD_LT_DSZ_LSB       6
`define RPD_LT_LEN_LSB       8
`define RPD_LT_WB_SEL        10
`define RPD_LT_DATA_RD       11
`define RPD_LT_PERR          12

// interrupt event bits
`define RPD_EV_PERR          0
`define RPD_EV_CENTRAL       1
`define RPD_EV_DECODED       2
`define RPD_EV_IGNORED       3
`define RPD_EV_LEN_RSVD      4
`define RPD_EV_W             5
`define RPD_IRQ_EN_RST       5'h00

// request phase timing: error phase is this many clocks after the strobe clock
`define RPD_ERR_PHASE_CLK    3

`endif

/* File: src/rpd_pkg.sv */
// types shared by the request phase decode and parity block
package rpd_pkg;

  typedef enum logic [3:0] {
    RPD_TXN_DEFER_REPLY,
    RPD_TXN_INT_ACK,
    RPD_TXN_SPECIAL,
    RPD_TXN_BRANCH_TRACE,
    RPD_TXN_IO_READ,
    RPD_TXN_IO_WRITE,
    RPD_TXN_MEM_RD_INVAL,
    RPD_TXN_MEM_WR_RSVD,
    RPD_TXN_MEM_READ,
    RPD_TXN_MEM_WRITE,
    RPD_TXN_CENTRAL_RSVD,
    RPD_TXN_IGNORE
  } rpd_txn_t;

  // request pins at their electrical level, all active low but parity
  typedef struct packed {
    logic       address_strobe_line_n;
    logic [4:0] request_code_n;
    logic       request_parity;
  } rpd_req_pins_t;

  typedef struct packed {
    rpd_txn_t   txn;
    logic [1:0] address_size_field;
    logic [1:0] data_size_field;
    logic [1:0] transfer_length_field;
    logic       write_or_writeback_select;
    logic       data_read;
    logic       len_reserved;
  } rpd_decoded_t;

endpackage

/* File: src/rpd_decode.sv */
// transaction type decode of the two request clock codes
`timescale 1ns/1ns
`default_nettype none

module rpd_decode
  import rpd_pkg::*;
(
  // codes in asserted sense, 1 = line low
  input  wire logic [4:0]   request_code_first_clock,
  input  wire logic [4:0]   request_code_second_clock,
  // decoded request
  output rpd_decoded_t      decoded
);

  logic [4:0] a;
  logic [1:0] lb;

  assign a  = request_code_first_clock;
  assign lb = request_code_second_clock[1:0];

  always_comb begin
    decoded                           = '0;
    decoded.address_size_field        = a[4:3];                       // [R8]
    decoded.data_size_field           = request_code_second_clock[4:3]; // [R3]
    decoded.transfer_length_field     = lb;                           // [R3]
    decoded.len_reserved              = (lb == 2'b11);                // [R13]
    decoded.write_or_writeback_select = a[1];                         // [R9]
    decoded.data_read                 = a[2] & a[1] & ~a[0];          // [R8]
    case (a)
      5'h00: decoded.txn = RPD_TXN_DEFER_REPLY;                       // [R7]
      5'h01: decoded.txn = RPD_TXN_IGNORE;                            // [R10]
      5'h08: begin
        if (lb == 2'b00) decoded.txn = RPD_TXN_INT_ACK;               // [R7]
        else if (lb == 2'b01) decoded.txn = RPD_TXN_SPECIAL;          // [R7]
        else decoded.txn = RPD_TXN_CENTRAL_RSVD;                      // [R10]
      end
      5'h09: begin
        if (lb == 2'b00) decoded.txn = RPD_TXN_BRANCH_TRACE;          // [R7]
        else decoded.txn = RPD_TXN_CENTRAL_RSVD;                      // [R10]
      end
      5'h10: decoded.txn = RPD_TXN_IO_READ;                           // [R7]
      5'h11: decoded.txn = RPD_TXN_IO_WRITE;                          // [R7]
      5'h18,
      5'h19: decoded.txn = RPD_TXN_IGNORE;                            // [R10]
      default: begin
        // every remaining first-clock code is a memory request
        case (a[2:0])
          3'b010:  decoded.txn = RPD_TXN_MEM_RD_INVAL;                // [R8]
          3'b011:  decoded.txn = RPD_TXN_MEM_WR_RSVD;
          3'b100,
          3'b110:  decoded.txn = RPD_TXN_MEM_READ;                    // [R8]
          3'b101,
          3'b111:  decoded.txn = RPD_TXN_MEM_WRITE;                   // [R9]
          default: decoded.txn = RPD_TXN_IGNORE;
        endcase
      end
    endcase
  end

endmodule

`default_nettype wire

/* File: src/rpd_top.sv */
// request phase receiver: decode, parity check, address error drive, apb registers
//
// Functional notes
// R1 - owner drives command lines, others sample both
// R2 - first code starts snoop, second completes
// R3 - second clock: size high, length low
// R4 - initiator drives parity over strobe, commands
// R5 - parity high for even count of lows
// R6 - mismatch asserts address error if enabled
// R7 - decode deferred, interrupt, special, trace, I/O
// R8 - memory: address size, invalidate, code/data read
// R9 - low bits 1x1 memory write, writeback select
// R10 - reserved groups need central agent; ignore others
// R11 - release bus outputs within two clocks
// R12 - latch configuration at reset release
// R13 - length codes 8, 16, 32 bytes, 11 reserved
// R14 - per clock parity, one flag, cleared after
`timescale 1ns/1ns
`default_nettype none
`include "rpd_params.svh"

module rpd_top
  import rpd_pkg::*;
#(
  parameter int CNT_W = 16
)(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // system bus, common clock with pclk
  input  wire rpd_req_pins_t req_pins,
  input  wire logic          bus_reset_n,
  input  wire logic          cfg_address_error_line_drive_n,
  output logic               address_error_line_o,
  output logic               address_error_line_oe_n,
  // interrupt
  output logic               irq
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("rpd_top: CNT_W must be 1 to 32");
  end

  // the walk strobe, second code, wait, drive puts the error phase at a fixed three clocks
  if (`RPD_ERR_PHASE_CLK != 3) begin : g_chk_err
    $error("rpd_top: the state walk serves an error phase of three clocks only");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_REQ_B, ST_ERR_WAIT, ST_ERR_DRIVE} rpd_state_t;

  // parity is correct when high for an even number of low lines
  function automatic logic parity_bad(input logic strobe_n, input logic [4:0] code_n, input logic par);
    logic expect_par;
    expect_par = ~(^(~{strobe_n, code_n}));                            // [R5]
    parity_bad = (par != expect_par);
  endfunction

  // ---------------- bus side state ----------------
  rpd_state_t   state_r, state_nxt;
  logic [4:0]   code_a_r, code_a_nxt;
  logic         perr_a_r, perr_a_nxt;
  logic         perr_flag_r, perr_flag_nxt;
  logic         address_error_line_r, address_error_line_nxt;
  logic         rst_seen_r, rst_seen_nxt;
  logic         cfg_address_error_line_r, cfg_address_error_line_nxt;
  rpd_decoded_t last_r, last_nxt;
  logic         last_perr_r, last_perr_nxt;
  logic [4:0]   events;
  logic [CNT_W-1:0] perr_cnt_r, perr_cnt_nxt;

  rpd_decoded_t dec;
  logic         perr_b;
  logic         strobe_seen;

  // the second code is decoded straight off the pins; its result is only used in ST_REQ_B
  rpd_decode u_decode (
    .request_code_first_clock  (code_a_r),
    .request_code_second_clock (~req_pins.request_code_n),
    .decoded                   (dec)
  );

  // the second clock has the strobe inactive, and that level is covered too
  assign perr_b      = parity_bad(req_pins.address_strobe_line_n, req_pins.request_code_n,
                                  req_pins.request_parity);            // [R4]
  assign strobe_seen = ~req_pins.address_strobe_line_n & rst_seen_r;

  logic check_en;
  logic perr_any;

  // a fault in either request clock makes one flag; each clock uses the enable it saw
  assign perr_any = perr_a_r | (check_en & perr_b);                    // [R14]

  always_comb begin
    state_nxt     = state_r;
    code_a_nxt    = code_a_r;
    perr_a_nxt    = perr_a_r;
    perr_flag_nxt = perr_flag_r;
    address_error_line_nxt      = 1'b0;
    last_nxt      = last_r;
    last_perr_nxt = last_perr_r;
    rst_seen_nxt  = bus_reset_n;
    cfg_address_error_line_nxt  = cfg_address_error_line_r;
    events        = '0;
    if (bus_reset_n && !rst_seen_r) begin
      cfg_address_error_line_nxt = ~cfg_address_error_line_drive_n;                                // [R12]
    end
    case (state_r)
      ST_IDLE,
      ST_ERR_DRIVE: begin
        if (strobe_seen) begin
          // first clock: sample type and check its parity on its own
          code_a_nxt = ~req_pins.request_code_n;                       // [R1] [R2]
          perr_a_nxt = check_en & parity_bad(req_pins.address_strobe_line_n,
                                             req_pins.request_code_n,
                                             req_pins.request_parity); // [R14]
          state_nxt  = ST_REQ_B;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_REQ_B: begin
        perr_flag_nxt = perr_any;                                      // [R14]
        last_nxt      = dec;                                           // [R2] [R3]
        last_perr_nxt = perr_any;
        state_nxt     = ST_ERR_WAIT;
        events[`RPD_EV_DECODED]  = (dec.txn != RPD_TXN_IGNORE);
        events[`RPD_EV_IGNORED]  = (dec.txn == RPD_TXN_IGNORE);        // [R10]
        events[`RPD_EV_CENTRAL]  = (dec.txn == RPD_TXN_CENTRAL_RSVD);  // [R10]
        events[`RPD_EV_LEN_RSVD] = dec.len_reserved;                   // [R13]
        events[`RPD_EV_PERR]     = perr_any;
      end
      ST_ERR_WAIT: begin
        // drive in the error phase clock, then drop the flag for the next request
        address_error_line_nxt      = perr_flag_r & cfg_address_error_line_r;                      // [R6]
        perr_flag_nxt = 1'b0;                                          // [R14]
        state_nxt     = ST_ERR_DRIVE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!bus_reset_n) begin
      // reset seen at an edge releases the pin at that same edge
      state_nxt     = ST_IDLE;
      address_error_line_nxt      = 1'b0;                                            // [R11]
      perr_flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_IDLE;
      code_a_r    <= '0;
      perr_a_r    <= 1'b0;
      perr_flag_r <= 1'b0;
      address_error_line_r      <= 1'b0;
      rst_seen_r  <= 1'b0;
      cfg_address_error_line_r  <= 1'b0;
      last_r      <= '0;
      last_perr_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      code_a_r    <= code_a_nxt;
      perr_a_r    <= perr_a_nxt;
      perr_flag_r <= perr_flag_nxt;
      address_error_line_r      <= address_error_line_nxt;
      rst_seen_r  <= rst_seen_nxt;
      cfg_address_error_line_r  <= cfg_address_error_line_nxt;
      last_r      <= last_nxt;
      last_perr_r <= last_perr_nxt;
    end
  end

  // ---------------- parity fault counter ----------------
  // saturates instead of wrapping so a fault storm never reads back as a few
  always_comb begin
    perr_cnt_nxt = perr_cnt_r;
    if (state_r == ST_REQ_B && perr_any && !(&perr_cnt_r)) begin
      perr_cnt_nxt = perr_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_cnt_r <= '0;
    end else begin
      perr_cnt_r <= perr_cnt_nxt;
    end
  end

  // open drain: oe_n low pulls the line low, otherwise released
  assign address_error_line_o    = 1'b0;
  assign address_error_line_oe_n = ~address_error_line_r;                            // [R6] [R11]

  // ---------------- apb registers ----------------
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [`RPD_EV_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [`RPD_EV_W-1:0] irq_en_r, irq_en_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        slverr_r, slverr_nxt;
  logic        wr_acc;
  logic [`RPD_EV_W-1:0] clr;

  assign check_en = ctrl_r[`RPD_CTRL_CHECK_EN];
  assign wr_acc   = psel & penable & pwrite;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `RPD_OFF_CTRL)     || (a == `RPD_OFF_STATUS) ||
              (a == `RPD_OFF_LAST_TXN) || (a == `RPD_OFF_IRQ_STAT) ||
              (a == `RPD_OFF_IRQ_EN)   || (a == `RPD_OFF_IRQ_CLR) ||
              (a == `RPD_OFF_PERR_CNT);
  endfunction

  // write access phase aimed at one register offset
  function automatic logic wr_hit(input logic acc, input logic [7:0] a, input logic [7:0] off);
    wr_hit = acc && (a == off);
  endfunction

  // ---------------- interrupt status ----------------
  always_comb begin
    clr = '0;
    if (wr_hit(wr_acc, paddr, `RPD_OFF_IRQ_CLR)) begin
      clr = pwdata[`RPD_EV_W-1:0];
    end
    // a new event in the clear cycle stays set
    irq_stat_nxt = (irq_stat_r & ~clr) | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // ---------------- register file ----------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    irq_en_nxt = irq_en_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (wr_hit(wr_acc, paddr, `RPD_OFF_CTRL)) begin
      // only the check enable exists; the other bits read back as zero
      ctrl_nxt = {31'h0000_0000, pwdata[`RPD_CTRL_CHECK_EN]};
    end
    if (wr_hit(wr_acc, paddr, `RPD_OFF_IRQ_EN)) begin
      irq_en_nxt = pwdata[`RPD_EV_W-1:0];
    end
    if (psel && !penable) begin
      // read data and error answer are prepared in the setup cycle
      slverr_nxt = ~addr_ok(paddr);
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `RPD_OFF_CTRL:     prdata_nxt = ctrl_r;
        `RPD_OFF_STATUS: begin
          prdata_nxt[`RPD_ST_ADDRESS_ERROR_LINE_CFG]  = cfg_address_error_line_r;
          prdata_nxt[`RPD_ST_BUS_RESET] = ~rst_seen_r;
          prdata_nxt[`RPD_ST_BUSY]      = (state_r != ST_IDLE);
        end
        `RPD_OFF_LAST_TXN: begin
          prdata_nxt[`RPD_LT_TXN_LSB +: 4] = last_r.txn;
          prdata_nxt[`RPD_LT_ASZ_LSB +: 2] = last_r.address_size_field;
          prdata_nxt[`RPD_LT_DSZ_LSB +: 2] = last_r.data_size_field;
          prdata_nxt[`RPD_LT_LEN_LSB +: 2] = last_r.transfer_length_field;
          prdata_nxt[`RPD_LT_WB_SEL]       = last_r.write_or_writeback_select;
          prdata_nxt[`RPD_LT_DATA_RD]      = last_r.data_read;
          prdata_nxt[`RPD_LT_PERR]         = last_perr_r;
        end
        `RPD_OFF_IRQ_STAT: prdata_nxt[`RPD_EV_W-1:0] = irq_stat_r;
        `RPD_OFF_IRQ_EN:   prdata_nxt[`RPD_EV_W-1:0] = irq_en_r;
        `RPD_OFF_PERR_CNT: prdata_nxt[CNT_W-1:0]     = perr_cnt_r;
        default:           prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `RPD_CTRL_RST;
      irq_en_r   <= `RPD_IRQ_EN_RST;
      prdata_r   <= '0;
      slverr_r   <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      irq_en_r   <= irq_en_nxt;
      prdata_r   <= prdata_nxt;
      slverr_r   <= slverr_nxt;
    end
  end

  // zero wait states: setup cycle already latched the answer
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = slverr_r & psel & penable;
  assign irq     = |(irq_stat_r & irq_en_r);

endmodule

`default_nettype wire

/* File: sim/rpd_asserts.sv */
// concurrent checks on the request phase receiver ports
`timescale 1ns/1ns
`default_nettype none
module rpd_asserts
  import rpd_pkg::*;
#(
  parameter int CNT_W = 16
)(
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // system bus and interrupt
  input wire rpd_req_pins_t req_pins,
  input wire logic          bus_reset_n,
  input wire logic          cfg_address_error_line_drive_n,
  input wire logic          address_error_line_o,
  input wire logic          address_error_line_oe_n,
  input wire logic          irq
);
  logic [1:0] hold_r, hold_nxt;
  logic       br_r, acc_r, pa_r, chk_r, strap_r, chk_nxt, strap_nxt, acc, fire;
  // strobes inside the three clock request window are not new requests
  assign acc       = !req_pins.address_strobe_line_n && hold_r == 2'h0 && bus_reset_n && br_r;
  assign hold_nxt  = !bus_reset_n ? 2'h0 : acc ? 2'h2 : hold_r - {1'b0, |hold_r};
  assign chk_nxt   = psel && penable && pwrite && paddr == 8'h00 ? pwdata[0] : chk_r;
  assign strap_nxt = bus_reset_n && !br_r ? !cfg_address_error_line_drive_n : strap_r;
  // even parity over all seven pins means the parity line disagrees
  assign fire      = acc_r && bus_reset_n && (pa_r || (~^req_pins && chk_r)) && strap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r  <= 2'h0;
      {br_r, acc_r, pa_r, strap_r} <= 4'h0;
      chk_r   <= 1'b1;
    end else begin
      hold_r  <= hold_nxt;
      br_r    <= bus_reset_n;
      acc_r   <= acc;
      pa_r    <= acc && ~^req_pins && chk_r;
      chk_r   <= chk_nxt;
      strap_r <= strap_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PERR_DRIVE: assert property (fire |-> ##2 !address_error_line_oe_n ##1 address_error_line_oe_n)
    else $error("address error pulse missing");
  AST_NO_SPURIOUS: assert property (!address_error_line_oe_n |-> $past(fire, 2))
    else $error("address error without parity fault");
  AST_BUS_RESET_RELEASE: assert property (!bus_reset_n |-> ##2 address_error_line_oe_n)
    else $error("output not released in bus reset");
  AST_STRAP_OFF: assert property (!strap_r |-> address_error_line_oe_n)
    else $error("address error driven while disabled");
  AST_CHECK_OFF: assert property (!chk_r [*4] |-> address_error_line_oe_n)
    else $error("address error driven with check off");
  AST_PULSE_ONE: assert property ($fell(address_error_line_oe_n) |=> $rose(address_error_line_oe_n))
    else $error("address error pulse too long");
  AST_UNMAPPED: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
    else $error("slave error wrong");
  AST_ZERO_WAIT: assert property (psel && !penable ##1 psel && penable |-> pready && !address_error_line_o)
    else $error("access phase stalled");
  cover property (fire);
  cover property (acc && !strap_r);
  cover property (psel && penable && pslverr);
endmodule
bind rpd_top rpd_asserts #(.CNT_W(CNT_W)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_pins(req_pins),
  .bus_reset_n(bus_reset_n), .cfg_address_error_line_drive_n(cfg_address_error_line_drive_n), .address_error_line_o(address_error_line_o),
  .address_error_line_oe_n(address_error_line_oe_n), .irq(irq));
`default_nettype wire

/* File: sim/rpd_initiator.sv */
// request initiator model: one two-clock request per go pulse
`timescale 1ns/1ns
`default_nettype none
module rpd_initiator
  import rpd_pkg::*;
(
  // clock
  input  wire logic         pclk,
  // request from the bench, flip bits corrupt parity per clock
  input  wire logic         go,
  input  wire logic [4:0]   code_a,
  input  wire logic [4:0]   code_b,
  input  wire logic [1:0]   flip,
  // bus side
  output var rpd_req_pins_t pins
);
  logic second_r = 1'b0;
  // released lines float to their high termination, which is also good parity
  initial pins = '1;
  always @(posedge pclk) begin
    second_r <= go;
    if (go) begin
      pins.address_strobe_line_n <= 1'b0;
      pins.request_code_n        <= ~code_a;
      pins.request_parity        <= ~^{1'b0, ~code_a} ^ flip[0];
    end else if (second_r) begin
      pins.address_strobe_line_n <= 1'b1;
      pins.request_code_n        <= ~code_b;
      pins.request_parity        <= ~^{1'b1, ~code_b} ^ flip[1];
    end else begin
      pins <= '1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/rpd_top_bench.sv */
// self-checking bench of the request phase receiver
`timescale 1ns/1ns
`default_nettype none
module rpd_top_bench
  import rpd_pkg::*;
;
  logic          pclk, presetn, psel, penable, pwrite, bus_reset_n, cfg_n, go, irq, oe_n, pready, rerr, rslv;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdata;
  logic [4:0]    code_a, code_b;
  logic [1:0]    flip;
  logic [13:0]   r;
  rpd_req_pins_t pins;
  int            err_total = 0, samples_checked = 0, cycles = 0, oe_low = 0, base;
  // first code, second code, decoded type; codes in asserted sense
  localparam logic [13:0] ROWS [17] = '{
    {5'h00, 5'h00, 4'h0}, {5'h08, 5'h00, 4'h1}, {5'h08, 5'h01, 4'h2}, {5'h08, 5'h02, 4'ha},
    {5'h09, 5'h00, 4'h3}, {5'h09, 5'h01, 4'ha}, {5'h10, 5'h01, 4'h4}, {5'h11, 5'h02, 4'h5},
    {5'h01, 5'h00, 4'hb}, {5'h18, 5'h00, 4'hb}, {5'h19, 5'h00, 4'hb}, {5'h0a, 5'h19, 4'h6},
    {5'h13, 5'h08, 4'h7}, {5'h04, 5'h02, 4'h8}, {5'h1e, 5'h10, 4'h8}, {5'h05, 5'h01, 4'h9},
    {5'h17, 5'h0a, 4'h9}};
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  rpd_top #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(rerr), .req_pins(pins),
    .bus_reset_n(bus_reset_n), .cfg_address_error_line_drive_n(cfg_n), .address_error_line_o(),
    .address_error_line_oe_n(oe_n), .irq(irq));
  rpd_initiator u_init (.pclk(pclk), .go(go), .code_a(code_a), .code_b(code_b), .flip(flip), .pins(pins));
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // counts address error low cycles; also cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (oe_n === 1'b0) oe_low++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata   = prdata;
    rslv    = rerr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic req(input logic [4:0] a, input logic [4:0] b, input logic [1:0] f);
    @(posedge pclk);
    go     <= 1'b1;
    code_a <= a;
    code_b <= b;
    flip   <= f;
    @(posedge pclk);
    go     <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, bus_reset_n, cfg_n, go} = 7'h00;
    {paddr, pwdata, code_a, code_b, flip} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    bus_reset_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    check(32'(rdata[0]), 32'h1);
    for (int i = 0; i < 17; i++) begin
      r = ROWS[i];
      req(r[13:9], r[8:4], 2'h0);
      apb(1'b0, 8'h08, 32'h0);
      check(32'({rdata[12], rdata[3:0]}), 32'(r[3:0]));
      if (r[3:0] inside {4'h6, 4'h7, 4'h8, 4'h9}) check(32'(rdata[9:4]), 32'({r[5:4], r[8:7], r[13:12]}));
      if (r[3:0] == 4'h8) check(32'(rdata[11]), 32'(r[10]));
      if (r[3:0] == 4'h9) check(32'(rdata[10]), 32'(r[10]));
      apb(1'b0, 8'h0c, 32'h0);
      check(32'(rdata[3:1]), r[3:0] == 4'hb ? 32'h4 : r[3:0] == 4'ha ? 32'h3 : 32'h2);
      apb(1'b1, 8'h14, 32'h1f);
    end
    // fault in first clock, second clock, then both: still one pulse each
    apb(1'b1, 8'h10, 32'h1);
    for (int k = 1; k < 4; k++) begin
      base = oe_low;
      req(5'h06, 5'h02, 2'(k));
      check(32'(oe_low - base), 32'h1);
      check(32'(irq), 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      check(rdata, 32'(k));
      apb(1'b1, 8'h14, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      check(32'(rdata[12]), 32'h1);
      check(32'(irq), 32'h0);
    end
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    req(5'h06, 5'h02, 2'h1);
    apb(1'b0, 8'h18, 32'h0);
    check(rdata, 32'h4);
    check(32'(irq), 32'h0);
    apb(1'b1, 8'h14, 32'h1f);
    // checking switched off: no pulse, count holds
    apb(1'b1, 8'h00, 32'h0);
    base = oe_low;
    req(5'h06, 5'h02, 2'h3);
    check(32'(oe_low - base), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(rdata, 32'h4);
    apb(1'b1, 8'h00, 32'h1);
    req(5'h04, 5'h03, 2'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check(32'(rdata[4:2]), 32'h5);
    // reset in mid run under bus reset, then strap disabled
    bus_reset_n <= 1'b0;
    cfg_n       <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rdata, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check({rdata[30:0], rslv}, 32'h1);
    bus_reset_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    check(32'(rdata[0]), 32'h0);
    base = oe_low;
    req(5'h06, 5'h02, 2'h1);
    check(32'(oe_low - base), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
